// *** core/plc_bit_manipulation_unit.sv ***
// Summary of operation
// - enabled unsigned compare drives output on when A is not above B
// - enabled set on a single bit forces that bit on
// - enabled set on a register writes all ones into it
// - a set or reset word changes all sixteen aliased bits together
// - a set bit or word keeps its value after the enable drops
// - enabled reset on a single bit clears that bit off
// - enabled reset on a register writes zero into it
// - a reset word holds zero until another instruction or a bus write changes it
// - enabled carry set forces the carry flag on, else untouched
// - enabled carry reset forces the carry flag off, else untouched
// - encode stores index of highest set bit of a 2^n table, n 1..8
// - empty encode table skips store, output off, error flag set
// - tables wider than sixteen bits run over consecutive registers
// - decode sets bit at low n source bits, clears rest of table
// - bit count writes number of one bits of source to destination
`timescale 1ns/1ps
`include "bitop_params.svh"

module plc_bit_manipulation_unit
	import bitop_pkg::*;
(
	input  wire logic        clk_in,     // 125 MHz scan clock
	input  wire logic        nrst_in,    // sync reset, active low
	input  wire logic        ce_in,      // clock enable, freezes state
	input  wire logic        psel_in,    // apb select
	input  wire logic        penable_in, // apb access phase
	input  wire logic        pwrite_in,  // apb direction, high = write
	input  wire logic [11:0] paddr_in,   // apb byte address
	input  wire logic [31:0] pwdata_in,  // apb write data
	output logic      [31:0] prdata_out, // apb read data, registered
	output logic             pready_out, // apb ready
	output logic             pslverr_out,// apb error on unmapped
	output logic             irq_out,    // level interrupt
	output logic             rung_out,   // instruction output
	output logic             carry_flag_out,      // carry flag
	output logic             instr_error_flag_out // error flag
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_e      state_reg, state_next;
	logic [31:0] cmd_reg, cmd_next;
	word_t       mem_reg  [16];
	word_t       mem_next [16];
	logic        rung_reg, rung_next;
	logic        carry_flag_reg, carry_flag_next;
	logic        instr_error_flag_reg, instr_error_flag_next;
	logic [1:0]  irq_stat_reg, irq_stat_next;
	logic [1:0]  irq_mask_reg, irq_mask_next;
	logic        rd_ready_reg, rd_ready_next;
	logic [31:0] prdata_reg, prdata_next;

	// ----------------------------------------------------------------
	// command fields
	// ----------------------------------------------------------------
	op_e        op;
	logic [3:0] tbl_n;
	logic       rung_en;
	logic       is_bit;
	logic [3:0] bit_idx;
	logic [3:0] a_addr;
	logic [3:0] b_addr;

	assign op      = op_e'(cmd_reg[`CMD_OP_LSB +: 4]);
	assign tbl_n   = cmd_reg[`CMD_N_LSB +: 4];
	assign rung_en = cmd_reg[`CMD_RUNG_BIT];
	assign is_bit  = cmd_reg[`CMD_ISBIT_BIT];
	assign bit_idx = cmd_reg[`CMD_BIDX_LSB +: 4];
	assign a_addr  = cmd_reg[`CMD_A_LSB +: 4];
	assign b_addr  = cmd_reg[`CMD_B_LSB +: 4];

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic       access;
	logic       wr_access;
	logic       rd_access;
	logic       hit_cmd;
	logic       hit_status;
	logic       hit_irq_stat;
	logic       hit_irq_mask;
	logic       hit_mem;
	logic       hit_any;
	logic [3:0] mem_idx;
	logic       ready_int;
	logic       wr_fire;
	logic       rd_fire;
	logic [31:0] rd_mux;

	assign access       = psel_in && penable_in;
	assign wr_access    = access && pwrite_in;
	assign rd_access    = access && !pwrite_in;
	assign hit_cmd      = paddr_in[11:2] == 10'(`OFF_CMD >> 2);
	assign hit_status   = paddr_in[11:2] == 10'(`OFF_STATUS >> 2);
	assign hit_irq_stat = paddr_in[11:2] == 10'(`OFF_IRQ_STAT >> 2);
	assign hit_irq_mask = paddr_in[11:2] == 10'(`OFF_IRQ_MASK >> 2);
	assign hit_mem      = paddr_in[11:6] == `MEM_PAGE;
	assign hit_any      = hit_cmd || hit_status || hit_irq_stat ||
	                      hit_irq_mask || hit_mem;
	assign mem_idx      = paddr_in[5:2];

	// writes wait out the execute cycle so the array has one writer
	assign ready_int   = pwrite_in ? (state_reg == st_idle) : rd_ready_reg;
	assign pready_out  = access && ready_int && ce_in;
	assign pslverr_out = pready_out && !hit_any;
	assign wr_fire     = wr_access && pready_out;
	assign rd_fire     = rd_access && pready_out;

	// read mux, captured one cycle before pready rises
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_cmd) begin
			rd_mux = cmd_reg;
		end else if (hit_status) begin
			rd_mux[`ST_RUNG_BIT]  = rung_reg;
			rd_mux[`ST_CARRY_BIT] = carry_flag_reg;
			rd_mux[`ST_ERR_BIT]   = instr_error_flag_reg;
			rd_mux[`ST_BUSY_BIT]  = state_reg == st_exec;
		end else if (hit_irq_stat) begin
			rd_mux[1:0] = irq_stat_reg;
		end else if (hit_irq_mask) begin
			rd_mux[1:0] = irq_mask_reg;
		end else if (hit_mem) begin
			rd_mux[15:0] = mem_reg[mem_idx];
		end
	end

	// ----------------------------------------------------------------
	// datapath helpers
	// ----------------------------------------------------------------
	word_t        word_a;
	word_t        word_b;
	logic [255:0] tbl_a;
	logic [255:0] tbl_mask;
	logic [255:0] dec_hot;
	logic [8:0]   tbl_size;
	logic [7:0]   dec_index;
	logic         n_ok;
	logic         enc_found;
	logic [7:0]   enc_pos;
	logic [4:0]   ones_cnt;
	word_t        dec_word [16];

	assign word_a    = mem_reg[a_addr];
	assign word_b    = mem_reg[b_addr];
	assign n_ok      = (tbl_n >= `N_MIN) && (tbl_n <= `N_MAX);
	assign tbl_size  = 9'h001 << tbl_n;
	// low n bits of the source select the table position
	assign dec_index = word_a[7:0] & 8'(tbl_size - 9'h001);

	// tables start at bit 0 of the named word and wrap past word 15
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_word
			logic [3:0] pos;
			word_t      m;
			word_t      h;
			assign tbl_a[gi*16 +: 16] = mem_reg[a_addr + 4'(gi)];
			assign pos = 4'(gi) - b_addr;
			assign m   = tbl_mask[{pos, 4'h0} +: 16];
			assign h   = dec_hot[{pos, 4'h0} +: 16];
			// bits outside the table keep their value
			assign dec_word[gi] = (mem_reg[gi] & ~m) | (h & m);
		end
	endgenerate

	// table mask, one-hot decode and highest set bit search
	always_comb begin
		tbl_mask  = '0;
		dec_hot   = '0;
		enc_found = 1'b0;
		enc_pos   = 8'h00;
		for (int i = 0; i < 256; i++) begin
			tbl_mask[i] = 9'(i) < tbl_size;
			dec_hot[i]  = 8'(i) == dec_index;
			// later hits overwrite, so the highest index wins
			if (tbl_a[i] && 9'(i) < tbl_size) begin
				enc_found = 1'b1;
				enc_pos   = 8'(i);
			end
		end
	end

	// population count of the source word
	always_comb begin
		ones_cnt = 5'h00;
		for (int i = 0; i < 16; i++) begin
			ones_cnt = ones_cnt + 5'(word_a[i]);
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next            = state_reg;
		cmd_next              = cmd_reg;
		mem_next              = mem_reg;
		rung_next             = rung_reg;
		carry_flag_next       = carry_flag_reg;
		instr_error_flag_next = instr_error_flag_reg;
		irq_stat_next         = irq_stat_reg;
		irq_mask_next         = irq_mask_reg;
		rd_ready_next         = rd_ready_reg;
		prdata_next           = prdata_reg;

		// read-to-clear first, so an event this cycle still lands
		if (rd_fire && hit_irq_stat) begin
			irq_stat_next = `IRQ_RST;
		end
		if (rd_access && !rd_ready_reg) begin
			rd_ready_next = 1'b1;
			prdata_next   = rd_mux;
		end else if (rd_fire) begin
			rd_ready_next = 1'b0;
		end

		// register writes only land while idle
		if (wr_fire) begin
			if (hit_cmd) begin
				cmd_next   = pwdata_in;
				state_next = st_exec;
			end else if (hit_status && pwdata_in[`ST_ERR_BIT]) begin
				instr_error_flag_next = 1'b0;
			end else if (hit_irq_mask) begin
				irq_mask_next = pwdata_in[1:0];
			end else if (hit_mem) begin
				mem_next[mem_idx] = pwdata_in[15:0];
			end
		end

		unique case (state_reg)
		st_idle: begin
		end
		st_exec: begin
			state_next                  = st_idle;
			irq_stat_next[`IRQ_DONE_BIT] = 1'b1;
			rung_next                   = 1'b1;
			if (!rung_en) begin
				rung_next = 1'b0;
			end else begin
				case (op)
				op_cmp_le: begin
					rung_next = word_a <= word_b;
				end
				op_set: begin
					if (is_bit) begin
						mem_next[a_addr][bit_idx] = 1'b1;
					end else begin
						mem_next[a_addr] = `WORD_ONES;
					end
				end
				op_rst: begin
					if (is_bit) begin
						mem_next[a_addr][bit_idx] = 1'b0;
					end else begin
						mem_next[a_addr] = `WORD_ZERO;
					end
				end
				carry_force_on: begin
					carry_flag_next = 1'b1;
				end
				carry_force_off: begin
					carry_flag_next = 1'b0;
				end
				priority_index_op: begin
					if (n_ok && enc_found) begin
						mem_next[b_addr] = word_t'(enc_pos);
					end else begin
						rung_next                   = 1'b0;
						instr_error_flag_next       = 1'b1;
						irq_stat_next[`IRQ_ERR_BIT] = 1'b1;
					end
				end
				one_hot_expand_op: begin
					if (n_ok) begin
						mem_next = dec_word;
					end else begin
						rung_next                   = 1'b0;
						instr_error_flag_next       = 1'b1;
						irq_stat_next[`IRQ_ERR_BIT] = 1'b1;
					end
				end
				ones_count_op: begin
					mem_next[b_addr] = word_t'(ones_cnt);
				end
				default: begin
					rung_next = 1'b0;
				end
				endcase
			end
		end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// stored words are never touched without a reset, an instruction or a write
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_reg            <= st_idle;
			cmd_reg              <= `CMD_RST;
			rung_reg             <= 1'b0;
			carry_flag_reg       <= 1'b0;
			instr_error_flag_reg <= 1'b0;
			irq_stat_reg         <= `IRQ_RST;
			irq_mask_reg         <= `IRQ_RST;
			rd_ready_reg         <= 1'b0;
			prdata_reg           <= `PRDATA_RST;
			for (int i = 0; i < 16; i++) begin
				mem_reg[i] <= `WORD_ZERO;
			end
		end else if (ce_in) begin
			state_reg            <= state_next;
			cmd_reg              <= cmd_next;
			rung_reg             <= rung_next;
			carry_flag_reg       <= carry_flag_next;
			instr_error_flag_reg <= instr_error_flag_next;
			irq_stat_reg         <= irq_stat_next;
			irq_mask_reg         <= irq_mask_next;
			rd_ready_reg         <= rd_ready_next;
			prdata_reg           <= prdata_next;
			mem_reg              <= mem_next;
		end
	end

	// outputs
	assign prdata_out           = prdata_reg;
	assign rung_out             = rung_reg;
	assign carry_flag_out       = carry_flag_reg;
	assign instr_error_flag_out = instr_error_flag_reg;
	assign irq_out              = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic fire;
	// only cycles that really advance count, so a held enable cannot trip
	assign fire = (state_reg == st_exec) && rung_en && ce_in;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in || !ce_in);

	sequence s_cmd_write;
		wr_fire && hit_cmd;
	endsequence

	sequence s_exec_once;
		state_reg == st_exec ##1 state_reg == st_idle;
	endsequence

	AST_CMD_SEQ: assert property (s_cmd_write |=> s_exec_once)
		else $error("command write did not run exactly one execute cycle");

	AST_CMP_LE: assert property (
		fire && op == op_cmp_le |=> rung_reg == ($past(word_a) <=
			$past(word_b)))
		else $error("compare output disagrees with operands");
	AST_BIT_SET: assert property (
		fire && op == op_set && is_bit |=> word_a[$past(bit_idx)])
		else $error("bit set left the bit off");
	AST_WORD_SET: assert property (
		fire && op == op_set && !is_bit |=> word_a == `WORD_ONES)
		else $error("word set did not write all ones");
	AST_WORD_RST: assert property (
		fire && op == op_rst && !is_bit |=> word_a == `WORD_ZERO)
		else $error("word reset did not write zero");
	AST_HOLD: assert property (
		state_reg == st_idle && !wr_fire |=> $stable(word_a))
		else $error("stored word changed without a writer");
	AST_CARRY_ON: assert property (
		fire && op == carry_force_on |=> carry_flag_reg)
		else $error("carry flag not set");
	AST_CARRY_OFF: assert property (
		fire && op == carry_force_off |=> !carry_flag_reg)
		else $error("carry flag not cleared");
	AST_ENC_STORE: assert property (
		fire && op == priority_index_op && n_ok && enc_found
		|=> word_b == word_t'($past(enc_pos)) && rung_reg)
		else $error("encode result wrong");
	AST_ENC_EMPTY: assert property (
		fire && op == priority_index_op && !enc_found
		|=> instr_error_flag_reg && !rung_reg && $stable(word_b))
		else $error("empty encode table not flagged");
	AST_COUNT: assert property (
		fire && op == ones_count_op |=> word_b == word_t'($past(ones_cnt)))
		else $error("bit count result wrong");
	AST_RUNG_OFF: assert property (
		state_reg == st_exec && ce_in && !rung_en
		|=> !rung_reg ##1 !rung_reg)
		else $error("output on while instruction disabled");

endmodule

// *** core/bitop_params.svh ***
`ifndef BITOP_PARAMS_SVH
`define BITOP_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD       12'h000
`define OFF_STATUS    12'h004
`define OFF_IRQ_STAT  12'h008
`define OFF_IRQ_MASK  12'h00C
`define MEM_PAGE      6'h01

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define CMD_OP_LSB    0
`define CMD_N_LSB     4
`define CMD_RUNG_BIT  8
`define CMD_ISBIT_BIT 9
`define CMD_BIDX_LSB  12
`define CMD_A_LSB     16
`define CMD_B_LSB     20

// ----------------------------------------------------------------
// status and interrupt fields
// ----------------------------------------------------------------
`define ST_RUNG_BIT   0
`define ST_CARRY_BIT  1
`define ST_ERR_BIT    2
`define ST_BUSY_BIT   3
`define IRQ_DONE_BIT  0
`define IRQ_ERR_BIT   1

// ----------------------------------------------------------------
// values and reset values
// ----------------------------------------------------------------
`define WORD_ONES     16'hFFFF
`define WORD_ZERO     16'h0000
`define N_MIN         4'h1
`define N_MAX         4'h8
`define CMD_RST       32'h0000_0000
`define IRQ_RST       2'h0
`define PRDATA_RST    32'h0000_0000

`endif

// *** core/bitop_pkg.sv ***
package bitop_pkg;

	// 16-bit data register word
	typedef logic [15:0] word_t;

	// instruction selector, low nibble of the command word
	typedef enum logic [3:0] {
		op_nop            = 4'h0,
		op_cmp_le         = 4'h1,
		op_set            = 4'h2,
		op_rst            = 4'h3,
		carry_force_on    = 4'h4,
		carry_force_off   = 4'h5,
		priority_index_op = 4'h6,
		one_hot_expand_op = 4'h7,
		ones_count_op     = 4'h8
	} op_e;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_exec = 2'b10
	} state_e;

endpackage

// *** sim/plc_bit_manipulation_unit_test.sv ***
`timescale 1ns/1ps
`include "bitop_params.svh"

module plc_bit_manipulation_unit_test
	import bitop_pkg::*;
;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	logic        clk_in;
	logic        nrst_in;
	logic        ce_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        irq_out;
	logic        rung_out;
	logic        carry_flag_out;
	logic        instr_error_flag_out;
	logic [31:0] rd_q;
	logic        err_q;
	int          fail_count;
	int          total_checks;
	int          cyc;
	// compare operands: equal, above, below, top bit set
	logic [15:0] ca [4] = '{16'h88B8, 16'h88B8, 16'h0000, 16'hFFFF};
	logic [15:0] cb [4] = '{16'h88B8, 16'h0000, 16'hFFFF, 16'h7FFF};
	logic [3:0]  cx     = 4'b0101;

	// clock enable driven, so one scenario can freeze the block
	plc_bit_manipulation_unit i_plc_bit_manipulation_unit (
		.clk_in               (clk_in),
		.nrst_in              (nrst_in),
		.ce_in                (ce_in),
		.psel_in              (psel_in),
		.penable_in           (penable_in),
		.pwrite_in            (pwrite_in),
		.paddr_in             (paddr_in),
		.pwdata_in            (pwdata_in),
		.prdata_out           (prdata_out),
		.pready_out           (pready_out),
		.pslverr_out          (pslverr_out),
		.irq_out              (irq_out),
		.rung_out             (rung_out),
		.carry_flag_out       (carry_flag_out),
		.instr_error_flag_out (instr_error_flag_out)
	);

	// 8 ns scan clock
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task end_sim;
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; ready, data and error are taken at the rising
	// edge that completes it, and only then is the request released
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd_q = prdata_out;
		err_q = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task rc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd_q, e);
	endtask

	// status bits and the flag pins must agree: error, carry, rung
	task fl(input logic [2:0] e);
		rc(`OFF_STATUS, {29'h0, e});
		chk({29'h0, instr_error_flag_out, carry_flag_out, rung_out},
			{29'h0, e});
	endtask

	function automatic logic [11:0] wa(input logic [3:0] i);
		return 12'h040 + {6'h0, i, 2'b00};
	endfunction

	task run(input op_e op, input logic [3:0] n, input logic en,
		input logic bsel, input logic [3:0] bi, input logic [3:0] a,
		input logic [3:0] b);
		xfer(1'b1, `OFF_CMD,
			{8'h00, b, a, bi, 2'b00, bsel, en, n, op});
	endtask

	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		nrst_in    = 1'b0;
		ce_in      = 1'b1;
		psel_in    = 1'b0;
		penable_in = 1'b0;
		pwrite_in  = 1'b0;
		paddr_in   = 12'h000;
		pwdata_in  = 32'h0;
		cyc        = 0;
		fail_count = 0;
		total_checks = 0;
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		fl(3'h0);
		rc(`OFF_IRQ_MASK, 32'h0);
		// word set survives a disabled instruction afterwards
		run(op_set, 4'h0, 1'b1, 1'b0, 4'h0, 4'h3, 4'h0);
		fl(3'h1);
		rc(wa(3), 32'hFFFF);
		run(op_rst, 4'h0, 1'b0, 1'b0, 4'h0, 4'h3, 4'h0);
		fl(3'h0);
		rc(wa(3), 32'hFFFF);
		// single bits, lowest and highest positions
		run(op_rst, 4'h0, 1'b1, 1'b1, 4'h0, 4'h3, 4'h0);
		rc(wa(3), 32'hFFFE);
		run(op_set, 4'h0, 1'b1, 1'b1, 4'h7, 4'h5, 4'h0);
		run(op_set, 4'h0, 1'b1, 1'b1, 4'hF, 4'h5, 4'h0);
		rc(wa(5), 32'h8080);
		run(op_rst, 4'h0, 1'b1, 1'b0, 4'h0, 4'h3, 4'h0);
		rc(wa(3), 32'h0);
		run(op_set, 4'h0, 1'b0, 1'b0, 4'h0, 4'h3, 4'h0);
		rc(wa(3), 32'h0);
		// carry flag, disabled runs leave it alone
		run(carry_force_on, 4'h0, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
		fl(3'h3);
		run(carry_force_off, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
		fl(3'h2);
		run(carry_force_off, 4'h0, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
		fl(3'h1);
		run(carry_force_on, 4'h0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0);
		fl(3'h0);
		// unsigned compare, values above 32767 included
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, wa(1), {16'h0, ca[i]});
			xfer(1'b1, wa(2), {16'h0, cb[i]});
			run(op_cmp_le, 4'h0, 1'b1, 1'b0, 4'h0, 4'h1, 4'h2);
			fl({2'b00, cx[i]});
		end
		// 32-bit table over words 7 and 8, highest one is bit 24
		xfer(1'b1, wa(7), 32'h0001);
		xfer(1'b1, wa(8), 32'h0100);
		run(priority_index_op, 4'h5, 1'b1, 1'b0, 4'h0, 4'h7, 4'h9);
		fl(3'h1);
		rc(wa(9), 32'h18);
		chk({31'h0, irq_out}, 32'h0);
		// empty table: no store, error raised and seen as interrupt
		xfer(1'b1, `OFF_IRQ_MASK, 32'h2);
		run(priority_index_op, 4'h4, 1'b1, 1'b0, 4'h0, 4'hA, 4'h9);
		fl(3'h4);
		rc(wa(9), 32'h18);
		chk({31'h0, irq_out}, 32'h1);
		rc(`OFF_IRQ_STAT, 32'h3);
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h0);
		xfer(1'b1, `OFF_STATUS, 32'h4);
		fl(3'h0);
		// decode: 4-entry table keeps the bits above it
		xfer(1'b1, wa(11), 32'h0003);
		xfer(1'b1, wa(12), 32'hFFFF);
		run(one_hot_expand_op, 4'h2, 1'b1, 1'b0, 4'h0, 4'hB, 4'hC);
		fl(3'h1);
		rc(wa(12), 32'hFFF8);
		// index 20 from the low five bits lands in word 13
		xfer(1'b1, wa(11), 32'hFFF4);
		xfer(1'b1, wa(13), 32'hFFFF);
		run(one_hot_expand_op, 4'h5, 1'b1, 1'b0, 4'h0, 4'hB, 4'hC);
		rc(wa(12), 32'h0);
		rc(wa(13), 32'h10);
		// nine ones in the source word
		xfer(1'b1, wa(14), 32'hA5F1);
		run(ones_count_op, 4'h0, 1'b1, 1'b0, 4'h0, 4'hE, 4'hF);
		rc(wa(15), 32'h9);
		// no-operation code and out-of-range table size both end off
		run(op_nop, 4'h0, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
		fl(3'h0);
		run(one_hot_expand_op, 4'h9, 1'b1, 1'b0, 4'h0, 4'hB, 4'hC);
		fl(3'h4);
		rc(wa(13), 32'h10);
		xfer(1'b1, `OFF_STATUS, 32'h4);
		// enable held low: the execute cycle waits and nothing moves
		run(carry_force_on, 4'h0, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
		ce_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk({31'h0, carry_flag_out}, 32'h0);
		ce_in <= 1'b1;
		fl(3'h3);
		// unmapped address answers with an error and zero data
		xfer(1'b0, 12'h100, 32'h0);
		chk(rd_q, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		end_sim();
	end
endmodule
